// file: rtl/sfq_defs.svh
`ifndef SFQ_DEFS_SVH
`define SFQ_DEFS_SVH

// ----------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------
`define SFQ_OP_WREN 8'h06
`define SFQ_OP_WRDI 8'h04
`define SFQ_OP_RDSR 8'h05
`define SFQ_OP_WRSR 8'h01
`define SFQ_OP_PP 8'h02
`define SFQ_OP_SE 8'hd8
`define SFQ_OP_SSE_A 8'hd7
`define SFQ_OP_SSE_B 8'h20
`define SFQ_OP_CE_A 8'hc7
`define SFQ_OP_CE_B 8'h60

// ----------------------------------------------------------------
// Whole bytes each command must carry, opcode included
// ----------------------------------------------------------------
`define SFQ_LEN_SHORT 3'h1
`define SFQ_LEN_WRSR 3'h2
`define SFQ_LEN_ERASE 3'h4
`define SFQ_LEN_PP_MIN 3'h5

// ----------------------------------------------------------------
// Status byte layout
// ----------------------------------------------------------------
`define SFQ_ST_BUSY 0
`define SFQ_ST_WEL 1

// ----------------------------------------------------------------
// Internal operation times in microseconds, and core clock rate
// ----------------------------------------------------------------
`define SFQ_CLK_MHZ 25
`define SFQ_T_SRW_US 5000
`define SFQ_T_PP_US 4000
`define SFQ_T_SSE_US 40000
`define SFQ_T_SE_US 80000
`define SFQ_T_CHE_US 250000

`endif

// file: rtl/sfq_pkg.sv
`default_nettype none
package sfq_pkg;

    // Kind of write-type operation handed to the array
    typedef enum logic [2:0] {
        SFQ_KIND_NONE = 3'h0,
        SFQ_KIND_WRSR = 3'h1,
        SFQ_KIND_PP = 3'h2,
        SFQ_KIND_SSE = 3'h3,
        SFQ_KIND_SE = 3'h4,
        SFQ_KIND_CE = 3'h5
    } sfq_kind_type;

    // Core sequencer states, Gray along idle -> busy -> idle
    typedef enum logic [0:0] {
        SFQ_ST_IDLE = 1'h0,
        SFQ_ST_BUSY = 1'h1
    } sfq_state_type;

endpackage
`default_nettype wire

// file: rtl/sfq_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfq_defs.svh"

module sfq_sequencer
    import sfq_pkg::*;
#(
    parameter int unsigned T_SRW_CYC = `SFQ_T_SRW_US * `SFQ_CLK_MHZ,
    parameter int unsigned T_PP_CYC = `SFQ_T_PP_US * `SFQ_CLK_MHZ,
    parameter int unsigned T_SSE_CYC = `SFQ_T_SSE_US * `SFQ_CLK_MHZ,
    parameter int unsigned T_SE_CYC = `SFQ_T_SE_US * `SFQ_CLK_MHZ,
    parameter int unsigned T_CHE_CYC = `SFQ_T_CHE_US * `SFQ_CLK_MHZ
) (
    // Core clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Serial link pins
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    output logic so_out,
    output logic so_oe_out,
    // Operation start towards the array
    output logic op_start_out,
    output sfq_kind_type op_kind_out,
    output logic [23:0] op_addr_out,
    output logic [7:0] sr_data_out,
    // Status
    output logic busy_out,
    output logic wel_out
);

    // ------------------------------------------------------------
    // Link domain state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [2:0] byte_cnt;
        logic [6:0] shift;
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [7:0] sr_data;
        logic aligned;
        logic [1:0] stat_s1;
        logic [1:0] stat_s2;
        logic [1:0] snap;
        logic seq;
    } sfq_link_type;

    // ------------------------------------------------------------
    // Core domain state
    // ------------------------------------------------------------
    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        sfq_state_type state;
        logic [25:0] timer;
        logic wel;
        logic start;
        sfq_kind_type kind;
        logic [23:0] addr;
        logic [7:0] sr_data;
        logic seen;
    } sfq_core_type;

    sfq_link_type link_reg;
    sfq_link_type link_next;
    sfq_core_type core_reg;
    sfq_core_type core_next;
    logic fresh_reg;
    logic so_reg;
    logic so_oe_reg;

    // Busy time for each operation kind, in core cycles
    // Defaults are typical times, all under the worst-case limits
    function automatic logic [25:0] op_time(input sfq_kind_type k);
        case (k)
            SFQ_KIND_WRSR: op_time = 26'(T_SRW_CYC);
            SFQ_KIND_PP: op_time = 26'(T_PP_CYC);
            SFQ_KIND_SSE: op_time = 26'(T_SSE_CYC);
            SFQ_KIND_SE: op_time = 26'(T_SE_CYC);
            SFQ_KIND_CE: op_time = 26'(T_CHE_CYC);
            default: op_time = 26'h0000001;
        endcase
    endfunction

    // Maps a captured command to a write-type operation
    function automatic sfq_kind_type op_decode(input logic [7:0] op,
                                               input logic [2:0] len);
        op_decode = SFQ_KIND_NONE;
        if (op == `SFQ_OP_WRSR && len == `SFQ_LEN_WRSR) begin
            op_decode = SFQ_KIND_WRSR;
        end else if (op == `SFQ_OP_PP && len >= `SFQ_LEN_PP_MIN) begin
            op_decode = SFQ_KIND_PP;
        end else if (op == `SFQ_OP_SE && len == `SFQ_LEN_ERASE) begin
            op_decode = SFQ_KIND_SE;
        end else if ((op == `SFQ_OP_SSE_A || op == `SFQ_OP_SSE_B)
                     && len == `SFQ_LEN_ERASE) begin
            op_decode = SFQ_KIND_SSE;
        end else if ((op == `SFQ_OP_CE_A || op == `SFQ_OP_CE_B)
                     && len == `SFQ_LEN_SHORT) begin
            op_decode = SFQ_KIND_CE;
        end
    endfunction

    // ------------------------------------------------------------
    // Link side: frame start marker
    // ------------------------------------------------------------
    // Set while deselected; the link clock is idle then, so the
    // counters are restarted by the first edge of the next frame.
    always_ff @(posedge sck_in or posedge cs_n_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fresh_reg <= 1'b1;
        end else if (cs_n_in) begin
            fresh_reg <= 1'b1;
        end else begin
            fresh_reg <= 1'b0;
        end
    end

    // Input shifter, byte counter and command capture
    always_comb begin
        logic [2:0] bits;
        logic [2:0] bytes;
        logic [7:0] sh;
        bits = fresh_reg ? 3'h0 : link_reg.bit_cnt;
        bytes = fresh_reg ? 3'h0 : link_reg.byte_cnt;
        sh = {link_reg.shift, si_in};
        link_next = link_reg;
        // Two-flop copy of core status into the link clock
        link_next.stat_s1 = {core_reg.wel, core_reg.state == SFQ_ST_BUSY};
        link_next.stat_s2 = link_reg.stat_s1;
        link_next.shift = sh[6:0];
        link_next.bit_cnt = 3'(bits + 3'h1);
        link_next.byte_cnt = bytes;
        link_next.aligned = 1'b0;
        // First edge of a frame flips the frame marker, so the core
        // can tell a real command from a select pulse with no clocks,
        // which would otherwise replay the previous frame's command.
        if (fresh_reg) begin
            link_next.seq = !link_reg.seq;
        end
        if (bits == 3'h7) begin
            // Byte complete; count saturates, enough for all lengths
            link_next.aligned = 1'b1;
            // Freeze both status bits for the byte that goes out next;
            // taking them bit by bit could show busy low with the
            // enable still high from a copy one clock older.
            link_next.snap = link_reg.stat_s2;
            if (bytes != 3'h7) begin
                link_next.byte_cnt = 3'(bytes + 3'h1);
            end
            if (bytes == 3'h0) begin
                link_next.opcode = sh;
            end
            if (bytes == 3'h1) begin
                link_next.sr_data = sh;
            end
            if (bytes >= 3'h1 && bytes <= 3'h3) begin
                link_next.addr = {link_reg.addr[15:0], sh};
            end
        end
    end

    // Link register bank
    // Runs only while the host clocks; nothing here sees clk_in
    always_ff @(posedge sck_in or negedge rstn_in) begin
        if (!rstn_in) begin
            link_reg <= '0;
        end else begin
            link_reg <= link_next;
        end
    end

    // ------------------------------------------------------------
    // Link side: status shift-out on the falling edge
    // ------------------------------------------------------------
    // Status byte repeats for as long as the host keeps clocking,
    // which lets it poll without reissuing the opcode.
    always_ff @(negedge sck_in or posedge cs_n_in or negedge rstn_in) begin
        if (!rstn_in) begin
            so_reg <= 1'b0;
            so_oe_reg <= 1'b0;
        end else if (cs_n_in) begin
            so_reg <= 1'b0;
            so_oe_reg <= 1'b0;
        end else if (!fresh_reg && link_reg.opcode == `SFQ_OP_RDSR
                     && link_reg.byte_cnt != 3'h0) begin
            // The fresh guard keeps a mode 3 frame, whose first edge
            // falls, from reusing the last frame's counters.
            so_oe_reg <= 1'b1;
            case (~link_reg.bit_cnt)
                3'(`SFQ_ST_BUSY): so_reg <= link_reg.snap[0];
                3'(`SFQ_ST_WEL): so_reg <= link_reg.snap[1];
                default: so_reg <= 1'b0;
            endcase
        end else begin
            so_reg <= 1'b0;
            so_oe_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Core side: command acceptance and busy timing
    // ------------------------------------------------------------
    // Captured link fields are read only after the synchronised
    // chip-select rise; they hold still until the next frame.
    always_comb begin
        sfq_kind_type kind;
        logic rise;
        logic newcmd;
        kind = op_decode(link_reg.opcode, link_reg.byte_cnt);
        rise = core_reg.cs_s2 && !core_reg.cs_s3;
        // Only a frame that clocked at least once carries a command
        newcmd = rise && (link_reg.seq != core_reg.seen);
        core_next = core_reg;
        core_next.cs_s1 = cs_n_in;
        core_next.cs_s2 = core_reg.cs_s1;
        core_next.cs_s3 = core_reg.cs_s2;
        core_next.start = 1'b0;
        // Every frame end is marked as judged, even while busy, so
        // the marker comparison stays right after long operations
        if (rise) begin
            core_next.seen = link_reg.seq;
        end
        case (core_reg.state)
            SFQ_ST_IDLE: begin
                // Commands count only on a whole-byte boundary
                if (newcmd && link_reg.aligned) begin
                    if (link_reg.opcode == `SFQ_OP_WREN
                        && link_reg.byte_cnt == `SFQ_LEN_SHORT) begin
                        core_next.wel = 1'b1;
                    end else if (link_reg.opcode == `SFQ_OP_WRDI
                                 && link_reg.byte_cnt == `SFQ_LEN_SHORT) begin
                        core_next.wel = 1'b0;
                    end else if (kind != SFQ_KIND_NONE && core_reg.wel) begin
                        core_next.state = SFQ_ST_BUSY;
                        core_next.start = 1'b1;
                        core_next.kind = kind;
                        core_next.addr = link_reg.addr;
                        core_next.sr_data = link_reg.sr_data;
                        core_next.timer = op_time(kind);
                    end
                end
            end
            SFQ_ST_BUSY: begin
                // Commands other than status reads are dropped here
                // Counter reaches one on the last busy cycle, so busy
                // stands for exactly the programmed number of cycles
                if (core_reg.timer <= 26'h0000001) begin
                    core_next.state = SFQ_ST_IDLE;
                    core_next.timer = 26'h0000000;
                    core_next.wel = 1'b0;
                end else begin
                    core_next.timer = 26'(core_reg.timer - 26'h0000001);
                end
            end
            default: core_next.state = SFQ_ST_IDLE;
        endcase
    end

    // Core register bank
    // Sync flops preset high: reset release is not a select rise
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            core_reg <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1,
                          state: SFQ_ST_IDLE, kind: SFQ_KIND_NONE,
                          default: '0};
        end else begin
            core_reg <= core_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign so_out = so_reg;
    assign so_oe_out = so_oe_reg;
    assign op_start_out = core_reg.start;
    assign op_kind_out = core_reg.kind;
    assign op_addr_out = core_reg.addr;
    assign sr_data_out = core_reg.sr_data;
    assign busy_out = core_reg.state == SFQ_ST_BUSY;
    assign wel_out = core_reg.wel;

endmodule // sfq_sequencer
`default_nettype wire

// file: sim/sfq_seq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Sequencer port checks
// ----------------------------------------------------------------
module sfq_seq_asserts
    import sfq_pkg::*;
#(
    parameter int unsigned T_SRW_CYC = 40,
    parameter int unsigned T_PP_CYC = 30,
    parameter int unsigned T_SSE_CYC = 50,
    parameter int unsigned T_SE_CYC = 60,
    parameter int unsigned T_CHE_CYC = 70
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic cs_n_in,
    input wire logic so_oe_out,
    input wire logic op_start_out,
    input wire sfq_kind_type op_kind_out,
    input wire logic busy_out,
    input wire logic wel_out
);
    logic [31:0] bcnt_reg;
    logic [31:0] lim;
    // Busy run length so far, counted in core cycles
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bcnt_reg <= '0;
        end else begin
            bcnt_reg <= busy_out ? bcnt_reg + 32'h1 : '0;
        end
    end
    // Expected busy length follows the kind of the running op
    assign lim = (op_kind_out == SFQ_KIND_WRSR) ? T_SRW_CYC :
                 (op_kind_out == SFQ_KIND_PP) ? T_PP_CYC :
                 (op_kind_out == SFQ_KIND_SSE) ? T_SSE_CYC :
                 (op_kind_out == SFQ_KIND_SE) ? T_SE_CYC : T_CHE_CYC;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    a_start_busy: assert property (
        op_start_out |-> busy_out && !$past(busy_out))
        else $error("start without fresh busy");
    a_start_wel: assert property (
        op_start_out |-> $past(wel_out))
        else $error("start without write enable");
    a_start_pulse: assert property (
        op_start_out |=> !op_start_out)
        else $error("start longer than one cycle");
    a_done_wel: assert property (
        $fell(busy_out) |-> !wel_out)
        else $error("write enable kept after op");
    a_start_cs: assert property (
        op_start_out |-> $past(cs_n_in) && $past(cs_n_in, 2))
        else $error("start while frame open");
    a_busy_bound: assert property (
        busy_out |-> bcnt_reg < lim)
        else $error("busy beyond its limit");
    a_busy_len: assert property (
        $fell(busy_out) |-> bcnt_reg == lim)
        else $error("busy length wrong");
    a_busy_rise: assert property (
        $rose(busy_out) |-> op_start_out)
        else $error("busy without start");
    a_oe_frame: assert property (
        so_oe_out |-> !cs_n_in)
        else $error("output driven while deselected");
    a_kind_set: assert property (
        op_start_out |-> op_kind_out != SFQ_KIND_NONE)
        else $error("start with no kind");
endmodule // sfq_seq_asserts
`default_nettype wire

// file: sim/sfq_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Host serial controller model, mode 0, 64 ns link clock
// ----------------------------------------------------------------
module sfq_host (
    output logic sck_out,
    output logic cs_n_out,
    output logic si_out,
    input wire logic so_in
);
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end
    // One frame, MSB first; clock idles low between frames
    task automatic xfer(input logic [39:0] d, input int n,
        output logic [7:0] rd);
        rd = 8'h00;
        cs_n_out = 1'b0;
        #32;
        for (int i = n - 1; i >= 0; i--) begin
            si_out = d[i];
            #32 sck_out = 1'b1;
            rd = {rd[6:0], so_in};
            #32 sck_out = 1'b0;
        end
        #32 cs_n_out = 1'b1;
        si_out = ~si_out; // Released line must not keep its value
        #256; // Gap well above the core's three cycles
    endtask
    // Busy poll with only status reads, bounded
    task automatic poll(output logic [7:0] rd);
        for (int k = 0; k < 400; k++) begin
            xfer(40'h0500, 16, rd);
            if (rd[0] === 1'b0) begin
                return;
            end
        end
    endtask
endmodule // sfq_host
`default_nettype wire

// file: sim/sfq_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Sequencer bench
// ----------------------------------------------------------------
module tb;
    import sfq_pkg::*;
    logic clk, rstn, sck, cs_n, si, so, so_oe, op_start, busy, wel;
    sfq_kind_type kind;
    logic [23:0] addr;
    logic [7:0] sr, rd;
    wire so_w = so_oe ? so : 1'b1; // Pull-up on the data out line
    int mismatches = 0, total_checks = 0, nstart = 0, bcnt = 0;
    sfq_sequencer #(.T_SRW_CYC(40), .T_PP_CYC(30), .T_SSE_CYC(50),
        .T_SE_CYC(60), .T_CHE_CYC(70)) sfq_sequencer_i (.clk_in(clk),
        .rstn_in(rstn), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
        .so_out(so), .so_oe_out(so_oe), .op_start_out(op_start),
        .op_kind_out(kind), .op_addr_out(addr), .sr_data_out(sr),
        .busy_out(busy), .wel_out(wel));
    sfq_host sfq_host_i (.sck_out(sck), .cs_n_out(cs_n), .si_out(si),
        .so_in(so_w));
    // Core clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Count starts and busy cycles away from the sampling edge
    always @(negedge clk) begin
        if (op_start === 1'b1) begin
            nstart++;
            bcnt = 1;
        end else if (busy === 1'b1) begin
            bcnt++;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out;
        if (mismatches == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Enable, run one write op, poll it out, judge ports
    task automatic run_op(input logic [39:0] d, input int n,
        input sfq_kind_type k, input int t);
        int s0;
        sfq_host_i.xfer(40'h06, 8, rd);
        sfq_host_i.xfer(40'h0500, 16, rd);
        chk("status wel", 1, rd[1]);
        s0 = nstart;
        sfq_host_i.xfer(d, n, rd);
        // One read while the shortest op still runs must show busy
        sfq_host_i.xfer(40'h0500, 16, rd);
        chk("status busy", 1, rd[0]);
        sfq_host_i.poll(rd);
        chk("starts", s0 + 1, nstart);
        chk("kind", k, kind);
        if (n >= 32) begin
            chk("addr", 24'(d >> (n - 32)), addr);
        end
        if (k == SFQ_KIND_WRSR) begin
            chk("sr data", d[7:0], sr);
        end
        chk("btime", t, bcnt);
        chk("poll done", 0, rd[1:0]);
        chk("wel", 0, wel);
    endtask
    // Write op without enable, then a frame cut mid-byte
    task automatic refused;
        int s0;
        s0 = nstart;
        sfq_host_i.xfer(40'hd8123456, 32, rd);
        chk("no enable", s0, nstart);
        sfq_host_i.xfer(40'h06, 8, rd);
        // Whole erase command plus one stray bit before the rise
        sfq_host_i.xfer(40'h1b02468ac, 33, rd);
        chk("cut frame", s0, nstart);
        chk("wel kept", 1, wel);
        chk("idle", 0, busy);
        sfq_host_i.xfer(40'h04, 8, rd);
        chk("wel off", 0, wel);
    endtask
    initial begin
        rstn = 1'b0;
        repeat (16) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        repeat (5) @(posedge clk);
        // Odd offset keeps every link edge off a core clock edge
        #13;
        run_op(40'hd8abcdef, 32, SFQ_KIND_SE, 60);
        run_op(40'hd7010203, 32, SFQ_KIND_SSE, 50);
        run_op(40'h20fedcba, 32, SFQ_KIND_SSE, 50);
        run_op(40'hc7, 8, SFQ_KIND_CE, 70);
        run_op(40'h60, 8, SFQ_KIND_CE, 70);
        run_op(40'h015a, 16, SFQ_KIND_WRSR, 40);
        run_op(40'h02a5c30f11, 40, SFQ_KIND_PP, 30);
        refused();
        close_out();
    end
    // Watchdog, several times the expected run
    initial begin
        #400000;
        mismatches++;
        close_out();
    end
endmodule // tb
bind sfq_sequencer sfq_seq_asserts #(.T_SRW_CYC(T_SRW_CYC),
    .T_PP_CYC(T_PP_CYC), .T_SSE_CYC(T_SSE_CYC), .T_SE_CYC(T_SE_CYC),
    .T_CHE_CYC(T_CHE_CYC)) chk_i (.clk_in(clk_in), .rstn_in(rstn_in),
    .cs_n_in(cs_n_in), .so_oe_out(so_oe_out), .op_start_out(op_start_out),
    .op_kind_out(op_kind_out), .busy_out(busy_out), .wel_out(wel_out));
`default_nettype wire
